// [hw/trig_demand_ctrl.v]
// Trigger sourcing, broadcast trigger delay and demand reporting logic.
// Assumes a register port master synchronous to clk and an external
// demand FIFO and highway transmitter that answer in the same clock.
`timescale 1ns/1ps
`include "trig_demand_defs.vh"

module trig_demand_ctrl #(
  parameter TICK_CYC = `PULSE_CYC
)
(
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // Bus interrupt request lines 7 to 1, bit 0 is line 1
  input wire [6:0] irq_lines,
  // Broadcast trigger message arrival, one-cycle pulse
  input wire bcast_msg,
  // Demand queue write side and state
  output reg demand_push,
  output reg [3:0] demand_source,
  input wire demand_queue_empty,
  input wire [3:0] demand_queue_head,
  output reg demand_pop,
  // Highway demand message transmitter
  output reg demand_msg_valid,
  output reg [3:0] demand_msg_source,
  input wire demand_msg_ready,
  // Trigger outputs
  output reg [7:0] ttl_trigger,
  output reg [1:0] ecl_trigger,
  output reg panel_trigger_out_a,
  output reg panel_trigger_out_b,
  // Interrupt
  output reg irq_out
);

  // ===================================================================
  // Functions
  function sel;
    input [7:0] a;
    input [7:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  function [3:0] lowest_level;
    input [6:0] v;
    integer i;
    begin
      lowest_level = 4'h0;
      for (i = `IRQ_LINES - 1; i >= 0; i = i - 1)
        if (v[i])
          lowest_level = i[3:0] + 4'h1;
    end
  endfunction

  // ===================================================================
  // Registers
  reg [6:0] irq_mon_mask_r;
  reg [`TRIG_W-1:0] bcast_pattern_r;
  reg [15:0] delay_count_r;
  reg dly_ena_r;
  reg demand_message_enable_r;
  reg [`EV_W-1:0] ev_status_r;
  reg [`EV_W-1:0] ev_mask_r;
  reg [6:0] irq_prev_r;
  reg [6:0] irq_pend_r;
  reg [`TRIG_W-1:0] src_fire_r;
  reg [`TRIG_W-1:0] bc_fire_r;
  reg bc_wait_r;
  reg [15:0] bc_left_r;
  reg [7:0] tick_r;
  reg sending_r;
  wire [`TRIG_W-1:0] trig_pulse;
  wire [`TRIG_W-1:0] fire_any;
  wire [6:0] irq_rise;
  wire [3:0] next_level;
  reg [`EV_W-1:0] ev_set;

  assign irq_rise = irq_lines & ~irq_prev_r & irq_mon_mask_r;
  assign next_level = lowest_level(irq_pend_r);
  assign fire_any = src_fire_r | bc_fire_r;

  // ===================================================================
  // Register writes
  always @(posedge clk)
  begin
    if (srst)
    begin
      irq_mon_mask_r <= 7'h00;
      bcast_pattern_r <= 12'h000;
      delay_count_r <= `RST_ZERO16;
      dly_ena_r <= 1'b0;
      demand_message_enable_r <= 1'b0;
      ev_mask_r <= 3'h0;
      src_fire_r <= 12'h000;
    end
    else
    begin
      src_fire_r <= 12'h000;
      if (reg_wr)
      begin
        if (sel(reg_addr, `OFF_INTERRUPT_LINE_MONITOR_MASK))
          irq_mon_mask_r <= reg_wdata[`IRQ_LINES-1:0];
        if (sel(reg_addr, `OFF_TRIGGER_PULSE_SOURCE))
          src_fire_r <= reg_wdata[`TRIG_W-1:0];
        if (sel(reg_addr, `OFF_BROADCAST_TRIGGER_PATTERN))
          bcast_pattern_r <= reg_wdata[`TRIG_W-1:0];
        if (sel(reg_addr, `OFF_BROADCAST_DELAY_COUNT))
          delay_count_r <= reg_wdata;
        if (sel(reg_addr, `OFF_CONTROL_STATUS_REGISTER))
        begin
          dly_ena_r <= reg_wdata[`CSR_DLY_ENA];
          demand_message_enable_r <= reg_wdata[`CSR_DEMAND_MESSAGE_ENABLE];
        end
        if (sel(reg_addr, `OFF_IRQ_MASK))
          ev_mask_r <= reg_wdata[`EV_W-1:0];
      end
    end
  end

  // ===================================================================
  // Broadcast trigger with optional delay
  always @(posedge clk)
  begin
    if (srst)
    begin
      bc_wait_r <= 1'b0;
      bc_left_r <= `RST_ZERO16;
      tick_r <= 8'h00;
      bc_fire_r <= 12'h000;
    end
    else
    begin
      bc_fire_r <= 12'h000;
      if (bcast_msg)
      begin
        // While the delay is enabled with a nonzero count, a new message restarts any delay still running.
        if (dly_ena_r && delay_count_r != 16'h0000)
        begin
          bc_wait_r <= 1'b1;
          bc_left_r <= delay_count_r;
          tick_r <= TICK_CYC[7:0] - 8'h01;
        end
        else
          bc_fire_r <= bcast_pattern_r;
      end
      else if (bc_wait_r)
      begin
        if (tick_r != 8'h00)
          tick_r <= tick_r - 8'h01;
        else if (bc_left_r == 16'h0001)
        begin
          bc_wait_r <= 1'b0;
          bc_left_r <= 16'h0000;
          bc_fire_r <= bcast_pattern_r;
        end
        else
        begin
          bc_left_r <= bc_left_r - 16'h0001;
          tick_r <= TICK_CYC[7:0] - 8'h01;
        end
      end
    end
  end

  trig_pulse_stretch #(
    .LINES(`TRIG_W),
    .CYC(`PULSE_CYC)
  ) u_stretch (
    .clk(clk),
    .srst(srst),
    .fire(fire_any),
    .pulse_out(trig_pulse)
  );

  always @(posedge clk)
  begin
    if (srst)
    begin
      ttl_trigger <= 8'h00;
      ecl_trigger <= 2'h0;
      panel_trigger_out_a <= 1'b0;
      panel_trigger_out_b <= 1'b0;
    end
    else
    begin
      ttl_trigger <= trig_pulse[7:0];
      ecl_trigger <= trig_pulse[9:8];
      panel_trigger_out_a <= trig_pulse[10];
      panel_trigger_out_b <= trig_pulse[11];
    end
  end

  // ===================================================================
  // Demand creation and messaging
  // Simultaneous edges are queued one per cycle, lowest level first.
  always @(posedge clk)
  begin
    if (srst)
    begin
      irq_prev_r <= 7'h00;
      irq_pend_r <= 7'h00;
      demand_push <= 1'b0;
      demand_source <= 4'h0;
      demand_pop <= 1'b0;
      demand_msg_valid <= 1'b0;
      demand_msg_source <= 4'h0;
      sending_r <= 1'b0;
    end
    else
    begin
      irq_prev_r <= irq_lines;
      demand_push <= 1'b0;
      demand_pop <= 1'b0;
      if (next_level != 4'h0)
      begin
        demand_push <= 1'b1;
        demand_source <= next_level;
        irq_pend_r <= (irq_pend_r & ~(7'h01 << (next_level - 4'h1))) | irq_rise;
      end
      else
        irq_pend_r <= irq_pend_r | irq_rise;
      // The transmitter interleaves these into outbound data on ready.
      if (sending_r)
      begin
        if (demand_msg_ready)
        begin
          demand_msg_valid <= 1'b0;
          demand_pop <= 1'b1;
          sending_r <= 1'b0;
        end
      end
      else if (demand_message_enable_r && !demand_queue_empty && !demand_pop)
      begin
        demand_msg_valid <= 1'b1;
        demand_msg_source <= demand_queue_head;
        sending_r <= 1'b1;
      end
    end
  end

  // ===================================================================
  // Event status, interrupt and read port
  always @*
  begin
    ev_set = 3'h0;
    ev_set[`EV_DEMAND] = demand_push;
    ev_set[`EV_BCAST] = |bc_fire_r;
    ev_set[`EV_TRIG] = |src_fire_r;
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      ev_status_r <= 3'h0;
      irq_out <= 1'b0;
      reg_rdata <= `RST_ZERO16;
    end
    else
    begin
      // A new event wins over a simultaneous write-one clear.
      if (reg_wr && sel(reg_addr, `OFF_IRQ_STATUS))
        ev_status_r <= (ev_status_r & ~reg_wdata[`EV_W-1:0]) | ev_set;
      else
        ev_status_r <= ev_status_r | ev_set;
      irq_out <= |(ev_status_r & ev_mask_r);
      reg_rdata <= `RST_ZERO16;
      if (reg_rd)
      begin
        // Write-only registers and unmapped addresses read as zero.
        if (sel(reg_addr, `OFF_IDENTITY_LOGICAL_ADDRESS))
          reg_rdata <= `RST_ID_READ;
        else if (sel(reg_addr, `OFF_DEVICE_TYPE_CODE))
          reg_rdata <= `RST_TYPE_CODE;
        else if (sel(reg_addr, `OFF_BROADCAST_DELAY_COUNT))
          reg_rdata <= delay_count_r;
        else if (sel(reg_addr, `OFF_CONTROL_STATUS_REGISTER))
        begin
          reg_rdata[`CSR_DLY_ENA] <= dly_ena_r;
          reg_rdata[`CSR_DEMAND_MESSAGE_ENABLE] <= demand_message_enable_r;
          reg_rdata[`CSR_DEMAND_PENDING_FLAG] <= ~demand_queue_empty;
        end
        else if (sel(reg_addr, `OFF_DEMAND_QUEUE_REGISTER))
          reg_rdata <= {12'h000, demand_queue_head};
        else if (sel(reg_addr, `OFF_IRQ_STATUS))
          reg_rdata <= {13'h0000, ev_status_r};
        else if (sel(reg_addr, `OFF_IRQ_MASK))
          reg_rdata <= {13'h0000, ev_mask_r};
      end
    end
  end

endmodule

// [pkg/trig_demand_defs.vh]
// Constants for the trigger sourcing and demand reporting block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef TRIG_DEMAND_DEFS_VH
`define TRIG_DEMAND_DEFS_VH

// =====================================================================
// Register offsets
`define OFF_IDENTITY_LOGICAL_ADDRESS 8'h00
`define OFF_DEVICE_TYPE_CODE 8'h02
`define OFF_CONFIG_STATUS_CONTROL 8'h04
`define OFF_INTERRUPT_LINE_MONITOR_MASK 8'h18
`define OFF_TRIGGER_PULSE_SOURCE 8'h20
`define OFF_BROADCAST_TRIGGER_PATTERN 8'h24
`define OFF_BROADCAST_DELAY_COUNT 8'h28
`define OFF_CONTROL_STATUS_REGISTER 8'h2c
`define OFF_DEMAND_QUEUE_REGISTER 8'h30
`define OFF_IRQ_STATUS 8'h34
`define OFF_IRQ_MASK 8'h38

// =====================================================================
// Field layouts
`define TRIG_W 12
`define IRQ_LINES 7
`define CSR_DLY_ENA 5
`define CSR_DEMAND_MESSAGE_ENABLE 9
`define CSR_DEMAND_PENDING_FLAG 10
`define DSC_W 4
`define DATA_W 16

// Status and mask bits of the interrupt registers.
`define EV_DEMAND 0
`define EV_BCAST 1
`define EV_TRIG 2
`define EV_W 3

// =====================================================================
// Reset values
`define RST_ZERO16 16'h0000
`define RST_ID_READ 16'h0000
`define RST_TYPE_CODE 16'h0000

// =====================================================================
// Timing
`define CLK_PERIOD_PS 4000
`define PULSE_PS 200000
`define PULSE_CYC (`PULSE_PS / `CLK_PERIOD_PS)

`endif

// [hw/trig_pulse_stretch.v]
// One pulse stretcher per trigger output line.
// Assumes a one-cycle fire strobe synchronous to clk.
`timescale 1ns/1ps
`include "trig_demand_defs.vh"

module trig_pulse_stretch #(
  parameter LINES = `TRIG_W,
  parameter CYC = `PULSE_CYC
)
(
  // Clock and reset
  input wire clk,
  input wire srst,
  // Fire strobes, one per line
  input wire [LINES-1:0] fire,
  // Stretched outputs, registered
  output reg [LINES-1:0] pulse_out
);

  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1)
    begin : line
      reg [7:0] cnt_r;
      always @(posedge clk)
      begin
        if (srst)
        begin
          cnt_r <= 8'h00;
          pulse_out[g] <= 1'b0;
        end
        else if (fire[g])
        begin
          // A new fire restarts the full width rather than cutting it short.
          cnt_r <= CYC[7:0] - 8'h01;
          pulse_out[g] <= 1'b1;
        end
        else if (cnt_r != 8'h00)
        begin
          cnt_r <= cnt_r - 8'h01;
        end
        else
        begin
          pulse_out[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// [bench/demand_far_side.sv]
// Far side model: external demand queue and highway transmitter.
// Assumes the block launches push, pop and valid on rising clk edges.
`timescale 1ns/1ps
module demand_far_side
(
  // Clock and reset
  input wire clk,
  input wire srst,
  // Queue side
  input wire demand_push,
  input wire [3:0] demand_source,
  input wire demand_pop,
  output wire demand_queue_empty,
  output wire [3:0] demand_queue_head,
  // Transmitter side
  input wire demand_msg_valid,
  input wire [3:0] demand_msg_source,
  output wire demand_msg_ready,
  input wire [7:0] stall
);
  reg [3:0] mem [0:15];
  reg [3:0] msg_log [0:15];
  reg [4:0] wp;
  reg [4:0] rp;
  reg [4:0] n_msgs;
  reg [7:0] wait_r;
  // =====================================================================
  // Queue and transmitter
  // An empty queue shows a stale head inverted, never a usable entry.
  assign demand_queue_empty = (wp == rp);
  assign demand_queue_head = (wp == rp) ? ~mem[rp[3:0]] : mem[rp[3:0]];
  // A stalled ready stands for a transmitter busy with a block transfer.
  assign demand_msg_ready = demand_msg_valid && (wait_r >= stall);
  always @(posedge clk)
  begin
    if (srst)
    begin
      wp <= 5'h00;
      rp <= 5'h00;
      n_msgs <= 5'h00;
      wait_r <= 8'h00;
    end
    else
    begin
      if (demand_push)
      begin
        mem[wp[3:0]] <= demand_source;
        wp <= wp + 5'h01;
      end
      if (demand_pop)
        rp <= rp + 5'h01;
      wait_r <= (demand_msg_valid && !demand_msg_ready) ? wait_r + 8'h01 : 8'h00;
      if (demand_msg_valid && demand_msg_ready)
      begin
        msg_log[n_msgs[3:0]] <= demand_msg_source;
        n_msgs <= n_msgs + 5'h01;
      end
    end
  end
endmodule

// [bench/trig_demand_asserts.sv]
// Checker for the trigger and demand block.
// Assumes only the ports of trig_demand_ctrl; attached by bind.
`timescale 1ns/1ps
`include "trig_demand_defs.vh"
module trig_demand_asserts #(
  parameter TICK_CYC = 50
)
(
  // Clock, reset, register port
  input wire clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // Events and far side
  input wire bcast_msg,
  input wire demand_push,
  input wire [3:0] demand_source,
  input wire demand_pop,
  input wire demand_msg_valid,
  input wire [3:0] demand_msg_source,
  input wire demand_msg_ready,
  // Outputs
  input wire [7:0] ttl_trigger,
  input wire [1:0] ecl_trigger,
  input wire panel_trigger_out_a,
  input wire panel_trigger_out_b,
  input wire irq_out
);
  wire [11:0] trig = {panel_trigger_out_b, panel_trigger_out_a, ecl_trigger, ttl_trigger};
  wire [11:0] wd = reg_wdata[11:0];
  reg [11:0] pat_r;
  reg dly_r;
  reg ena_r;
  // =====================================================================
  // Shadow of the write-only broadcast pattern and of the readable CSR enable bits.
  always @(posedge clk)
  begin
    if (srst)
    begin
      pat_r <= 12'h000;
      dly_r <= 1'b0;
      ena_r <= 1'b0;
    end
    else if (reg_wr && reg_addr == `OFF_BROADCAST_TRIGGER_PATTERN)
      pat_r <= wd;
    else if (reg_wr && reg_addr == `OFF_CONTROL_STATUS_REGISTER)
    begin
      dly_r <= reg_wdata[`CSR_DLY_ENA];
      ena_r <= reg_wdata[`CSR_DEMAND_MESSAGE_ENABLE];
    end
  end
  // =====================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence src_wr;
    reg_wr && reg_addr == `OFF_TRIGGER_PULSE_SOURCE;
  endsequence
  sequence msg_taken;
    demand_msg_valid && demand_msg_ready;
  endsequence
  chk_pulse_width: assert property (src_wr ##0 reg_wdata[0] |-> ##3 ttl_trigger[0] ##49 ttl_trigger[0])
    else $error("trigger pulse too short");
  chk_lane_map: assert property (src_wr |-> ##3 (trig & $past(wd, 3)) == $past(wd, 3))
    else $error("trigger lane missing");
  chk_bcast_now: assert property (bcast_msg && !dly_r |-> ##3 (trig & pat_r) == pat_r)
    else $error("broadcast pattern not asserted");
  chk_msg_hold: assert property (demand_msg_valid && !demand_msg_ready |=> demand_msg_valid && $stable(demand_msg_source))
    else $error("demand message dropped before ready");
  chk_pop_after: assert property (msg_taken |=> demand_pop && !demand_msg_valid)
    else $error("no pop after message taken");
  chk_src_level: assert property (demand_push |-> demand_source inside {[4'h1:4'h7]})
    else $error("demand source out of range");
  chk_msg_quiet: assert property (!ena_r && !$past(ena_r) |-> !$rose(demand_msg_valid))
    else $error("message sent while disabled");
  chk_wo_read: assert property ($past(reg_rd) && $past(reg_addr) == `OFF_INTERRUPT_LINE_MONITOR_MASK |-> reg_rdata == 16'h0000)
    else $error("write-only register read back");
  chk_irq_off: assert property (reg_wr && reg_addr == `OFF_IRQ_MASK && reg_wdata[2:0] == 3'h0 |-> ##2 !irq_out)
    else $error("interrupt high while masked");
endmodule
bind trig_demand_ctrl trig_demand_asserts #(.TICK_CYC(TICK_CYC)) u_chk (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bcast_msg(bcast_msg), .demand_push(demand_push),
  .demand_source(demand_source), .demand_pop(demand_pop), .demand_msg_valid(demand_msg_valid),
  .demand_msg_source(demand_msg_source), .demand_msg_ready(demand_msg_ready),
  .ttl_trigger(ttl_trigger), .ecl_trigger(ecl_trigger), .panel_trigger_out_a(panel_trigger_out_a),
  .panel_trigger_out_b(panel_trigger_out_b), .irq_out(irq_out));

// [bench/trig_demand_ctrl_tb.sv]
// Self-checking bench for trig_demand_ctrl and its far side model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`include "trig_demand_defs.vh"
module trig_demand_ctrl_tb;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [7:0] a = 8'h00;
  reg [15:0] d = 16'h0000;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg [6:0] irq_lines = 7'h00;
  reg bcast = 1'b0;
  reg [7:0] stall = 8'h03;
  wire [15:0] rdata;
  wire push, pop, empty, valid, ready, pa, pb, irq_out;
  wire [3:0] src, head, msrc;
  wire [7:0] ttl;
  wire [1:0] ecl;
  wire [15:0] trig = {4'h0, pb, pa, ecl, ttl};
  int n_errors = 0;
  int total_checks = 0;
  int i;
  typedef struct packed {logic [15:0] wd; logic [15:0] ex;} row_t;
  row_t rows [6] = '{'{16'h0001, 16'h0001}, '{16'h0080, 16'h0080}, '{16'h0300, 16'h0300},
    '{16'h0400, 16'h0400}, '{16'h0800, 16'h0800}, '{16'hf0a5, 16'h00a5}};
  always #2 clk = ~clk;
  trig_demand_ctrl #(.TICK_CYC(50)) DUT (.clk(clk), .srst(srst), .reg_addr(a),
    .reg_wdata(d), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .irq_lines(irq_lines),
    .bcast_msg(bcast), .demand_push(push), .demand_source(src), .demand_queue_empty(empty),
    .demand_queue_head(head), .demand_pop(pop), .demand_msg_valid(valid),
    .demand_msg_source(msrc), .demand_msg_ready(ready), .ttl_trigger(ttl),
    .ecl_trigger(ecl), .panel_trigger_out_a(pa), .panel_trigger_out_b(pb), .irq_out(irq_out));
  demand_far_side far (.clk(clk), .srst(srst), .demand_push(push), .demand_source(src),
    .demand_pop(pop), .demand_queue_empty(empty), .demand_queue_head(head),
    .demand_msg_valid(valid), .demand_msg_source(msrc), .demand_msg_ready(ready), .stall(stall));
  // =====================================================================
  // Tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task cyc(input int n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  task wr(input logic [7:0] ad, input logic [15:0] dt);
  begin
    @(posedge clk);
    wr_s <= 1'b1;
    a <= ad;
    d <= dt;
    @(posedge clk);
    wr_s <= 1'b0;
  end
  endtask
  task rd(input logic [7:0] ad, input logic [15:0] exp);
  begin
    @(posedge clk);
    rd_s <= 1'b1;
    a <= ad;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  end
  endtask
  task bc;
  begin
    @(posedge clk);
    bcast <= 1'b1;
    @(posedge clk);
    bcast <= 1'b0;
  end
  endtask
  task final_report;
  begin
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // =====================================================================
  // Sequence
  initial
  begin
    cyc(9);
    chk(trig | rdata, 16'h0000);
    chk({12'h000, push, pop, valid, irq_out}, 16'h0000);
    @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 6; i++)
    begin
      wr(`OFF_TRIGGER_PULSE_SOURCE, rows[i].wd);
      cyc(3);
      chk(trig, rows[i].ex);
      cyc(48);
      chk(trig, rows[i].ex);
      cyc(1);
      chk(trig, 16'h0000);
    end
    wr(`OFF_BROADCAST_TRIGGER_PATTERN, 16'hfc21);
    wr(`OFF_CONTROL_STATUS_REGISTER, 16'h0000);
    wr(`OFF_TRIGGER_PULSE_SOURCE, 16'h0002);
    bc();
    cyc(3);
    chk(trig, 16'h0c23);
    cyc(60);
    wr(`OFF_BROADCAST_DELAY_COUNT, 16'h0003);
    rd(`OFF_BROADCAST_DELAY_COUNT, 16'h0003);
    wr(`OFF_CONTROL_STATUS_REGISTER, 16'h0020);
    rd(`OFF_CONTROL_STATUS_REGISTER, 16'h0020);
    bc();
    // The delayed pattern shows exactly three ticks later than an undelayed one.
    cyc(151);
    chk(trig, 16'h0000);
    cyc(1);
    chk(trig, 16'h0c21);
    cyc(60);
    rd(`OFF_IRQ_STATUS, 16'h0006);
    wr(`OFF_IRQ_MASK, 16'h0002);
    cyc(2);
    chk({15'h0000, irq_out}, 16'h0001);
    wr(`OFF_IRQ_STATUS, 16'h0006);
    rd(`OFF_IRQ_STATUS, 16'h0000);
    chk({15'h0000, irq_out}, 16'h0000);
    wr(`OFF_IRQ_MASK, 16'h0000);
    rd(8'h3c, 16'h0000);
    rd(`OFF_TRIGGER_PULSE_SOURCE, 16'h0000);
    rd(`OFF_INTERRUPT_LINE_MONITOR_MASK, 16'h0000);
    // Line 2 rises too but is left out of the mask.
    wr(`OFF_CONTROL_STATUS_REGISTER, 16'h0000);
    wr(`OFF_INTERRUPT_LINE_MONITOR_MASK, 16'h0005);
    @(posedge clk);
    irq_lines <= 7'h07;
    cyc(10);
    chk({11'h000, far.wp - far.rp}, 16'h0002);
    chk({8'h00, far.mem[0], far.mem[1]}, 16'h0013);
    chk({11'h000, far.n_msgs}, 16'h0000);
    chk({15'h0000, irq_out}, 16'h0000);
    rd(`OFF_DEMAND_QUEUE_REGISTER, 16'h0001);
    rd(`OFF_CONTROL_STATUS_REGISTER, 16'h0400);
    wr(`OFF_CONTROL_STATUS_REGISTER, 16'h0200);
    for (i = 0; i < 100 && far.n_msgs != 5'h02; i++)
      @(posedge clk);
    if (i == 100)
      n_errors++;
    else
    begin
      cyc(3);
      chk({8'h00, far.msg_log[0], far.msg_log[1]}, 16'h0013);
      chk({15'h0000, empty}, 16'h0001);
    end
    irq_lines <= 7'h00;
    final_report;
  end
endmodule
